// File: logic/crs_acc_filter.v
// Acceptance filter and storage-priority selector for 16 buffers
// Assumes flattened buffer configuration from the receive store
`timescale 1ns/1ns
`default_nettype none
`include "crs_rx_store_map.vh"

module crs_acc_filter (
    input  wire [28:0]  rx_id,
    input  wire [463:0] buf_id_flat,
    input  wire [47:0]  buf_type_flat,
    input  wire [15:0]  buf_in_use,
    input  wire [15:0]  buf_ready,
    input  wire [15:0]  buf_stored,
    input  wire [15:0]  buf_ows,
    input  wire [115:0] mask_flat,
    output reg          hit,
    output reg  [3:0]   hit_idx,
    output wire         hit_ok
);
    // ==========================================================
    // Per-buffer match
    wire [15:0] cand;                   // Eligible and matching
    genvar g;
    generate
        for (g = 0; g < `CRS_NBUF; g = g + 1) begin : g_buf
            wire [2:0]  t  = buf_type_flat[g*3 +: 3];
            wire [1:0]  mi = t[1:0] - 2'h2;   // Mask 1..4 -> 0..3
            // Unmasked buffers compare every bit
            wire [28:0] m  = (t == `CRS_TYPE_NOMASK) ? 29'h0000_0000
                           : mask_flat[mi*29 +: 29];
            // Mask bit 1 skips the bit, 0 compares it
            wire eq = (((rx_id ^ buf_id_flat[g*29 +: 29]) & ~m)
                      == 29'h0000_0000);                      // RL17
            assign cand[g] = buf_in_use[g] & buf_ready[g] & eq
                           & (t >= `CRS_TYPE_NOMASK)
                           & (t <= `CRS_TYPE_MAX);            // RL18 RL16
        end
    endgenerate

    // ==========================================================
    // Lowest type code wins, then lowest number
    reg [2:0] best;                     // Best class so far
    integer   i;
    always @* begin
        best    = `CRS_TYPE_NONE;
        hit     = 1'b0;
        hit_idx = 4'h0;
        for (i = 0; i < `CRS_NBUF; i = i + 1) begin
            if (cand[i] && (buf_type_flat[i*3 +: 3] < best)) begin
                best    = buf_type_flat[i*3 +: 3];          // RL19
                hit     = 1'b1;
                hit_idx = i[3:0];
            end
        end
    end

    // Only the winner is judged; a refusal drops the frame
    assign hit_ok = ~buf_stored[hit_idx] | buf_ows[hit_idx]; // RL20 RL19

endmodule // crs_acc_filter
`default_nettype wire

// File: logic/crs_rx_store.v
// Receive storage: buffer flags, reception-order log, mask filtering
// Assumes frames from a protocol engine on the same clock, and a
// simple register port with read data one cycle after the strobe
//
// Function
// [RL1] Stored flag set at store start and end
// [RL2] Update flag spans store, clears at end
// [RL3] Log buffer number just before storing
// [RL4] Ready bit locked while update runs
// [RL5] Store stalls on same-buffer CPU access
// [RL6] Log of 23 entries, two pointers
// [RL7] Log contents undefined after init exit
// [RL8] Last-in reads entry at write pointer minus one
// [RL9] Record at write pointer, then increment
// [RL10] Get read returns oldest, then increments
// [RL11] Empty when pointers equal, cleared on record
// [RL12] Overflow when write reaches read minus one
// [RL13] When full, overwrite newest entry
// [RL14] Overflow sticks until software clears it
// [RL15] Empty not cleared while overflowed
// [RL16] Buffer uses no mask or one of four
// [RL17] Mask one skips bit, zero compares
// [RL18] Candidate needs in-use, receive type, ready
// [RL19] Unmasked first, then masks one to four
// [RL20] Accept if not stored or overwrite allowed
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "crs_rx_store_map.vh"

module crs_rx_store (
    input  wire        clk_sys,
    input  wire        nrst,
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata_ff,
    input  wire        rx_frame_valid,
    input  wire [28:0] rx_id,
    input  wire [63:0] rx_data,
    output reg         store_busy_ff,
    output reg         log_empty_ff,
    output reg         log_overflow_ff,
    output reg         rx_stored_pulse_ff
);
    // ==========================================================
    // Store sequencer states
    localparam [3:0] S_IDLE  = 4'h1;    // Waiting for a frame
    localparam [3:0] S_LOG   = 4'h2;    // Record buffer number
    localparam [3:0] S_STORE = 4'h4;    // Write id and data
    localparam [3:0] S_DONE  = 4'h8;    // Final flag update

    // ==========================================================
    // Storage
    reg         mode_ff;                // 1 = operation mode
    reg  [28:0] mask_ff [0:3];          // Global masks
    reg  [28:0] bid_ff  [0:15];         // Buffer identifier
    reg  [31:0] dlo_ff  [0:15];         // Buffer data low word
    reg  [31:0] dhi_ff  [0:15];         // Buffer data high word
    reg  [2:0]  type_ff [0:15];         // buffer_type_field
    reg  [15:0] rdy_ff;                 // Ready bits
    reg  [15:0] stored_ff;              // message_stored_flag
    reg  [15:0] muc_ff;                 // buffer_update_in_progress
    reg  [15:0] ows_ff;                 // overwrite_permit
    reg  [15:0] inuse_ff;               // buffer_in_use
    reg  [3:0]  log_ff  [0:22];         // reception_order_log
    reg  [4:0]  wptr_ff;                // log_write_pointer
    reg  [4:0]  rptr_ff;                // log_read_pointer
    reg  [3:0]  state_ff;               // Sequencer state
    reg  [3:0]  nxt_state;
    reg  [1:0]  step_ff;                // Word being stored
    reg  [3:0]  tgt_ff;                 // Target buffer
    reg  [28:0] cap_id_ff;              // Captured frame id
    reg  [63:0] cap_data_ff;            // Captured frame data

    // ==========================================================
    // Pointer arithmetic modulo the log depth
    function [4:0] ptr_inc;
        input [4:0] p;
        begin
            ptr_inc = (p == `CRS_LOG_LAST) ? 5'h00 : p + 5'h01;
        end
    endfunction

    function [4:0] ptr_dec;
        input [4:0] p;
        begin
            ptr_dec = (p == 5'h00) ? `CRS_LOG_LAST : p - 5'h01;
        end
    endfunction

    // ==========================================================
    // Address decode
    wire       buf_sel = (reg_addr[7:6] == `CRS_A_BUF_HI);
    wire [3:0] bidx    = reg_addr[5:2];
    wire [1:0] bfld    = reg_addr[1:0];
    wire       msk_sel = (reg_addr[7:2] == `CRS_A_MASK_HI);
    wire       get_rd  = reg_rd & mode_ff & (reg_addr == `CRS_A_GET);
    wire       ovf_clr = reg_wr & (reg_addr == `CRS_A_GET)
                       & reg_wdata[`CRS_GET_OVF];
    wire       cpu_hit = (reg_wr | reg_rd) & buf_sel & (bidx == tgt_ff);
    wire       b_wr    = reg_wr & buf_sel;

    // Sequencer events
    wire       rec      = (state_ff == S_LOG);
    wire       st_go    = (state_ff == S_STORE) & ~cpu_hit;     // RL5
    wire       st_first = (state_ff == S_STORE) & (step_ff == 2'h0);
    wire       st_end   = (state_ff == S_DONE);

    // ==========================================================
    // Acceptance filter
    wire [463:0] id_flat;
    wire [47:0]  type_flat;
    wire [115:0] mask_flat;
    wire         hit;
    wire [3:0]   hit_idx;
    wire         hit_ok;
    genvar g;
    generate
        for (g = 0; g < `CRS_NBUF; g = g + 1) begin : g_flat
            assign id_flat[g*29 +: 29] = bid_ff[g];
            assign type_flat[g*3 +: 3] = type_ff[g];
        end
        for (g = 0; g < 4; g = g + 1) begin : g_mflat
            assign mask_flat[g*29 +: 29] = mask_ff[g];
        end
    endgenerate

    crs_acc_filter u_filt (
        .rx_id         (rx_id),
        .buf_id_flat   (id_flat),
        .buf_type_flat (type_flat),
        .buf_in_use    (inuse_ff),
        .buf_ready     (rdy_ff),
        .buf_stored    (stored_ff),
        .buf_ows       (ows_ff),
        .mask_flat     (mask_flat),
        .hit           (hit),
        .hit_idx       (hit_idx),
        .hit_ok        (hit_ok)
    );

    wire accept = (state_ff == S_IDLE) & mode_ff & rx_frame_valid
                & hit & hit_ok;                             // RL20

    // ==========================================================
    // Sequencer next state
    always @* begin
        case (state_ff)
            S_IDLE:  nxt_state = accept ? S_LOG : S_IDLE;
            S_LOG:   nxt_state = S_STORE;                   // RL3
            S_STORE: nxt_state = (st_go && step_ff == `CRS_STEP_LAST)
                               ? S_DONE : S_STORE;
            S_DONE:  nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end

    // Sequencer registers and frame capture
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_ff           <= S_IDLE;
            step_ff            <= 2'h0;
            tgt_ff             <= 4'h0;
            cap_id_ff          <= 29'h0000_0000;
            cap_data_ff        <= 64'h0000_0000_0000_0000;
            store_busy_ff      <= 1'b0;
            rx_stored_pulse_ff <= 1'b0;
        end else begin
            state_ff           <= nxt_state;
            store_busy_ff      <= (nxt_state != S_IDLE);
            rx_stored_pulse_ff <= st_end;
            // Latch the frame so the engine may move on
            if (accept) begin
                tgt_ff      <= hit_idx;
                cap_id_ff   <= rx_id;
                cap_data_ff <= rx_data;
                step_ff     <= 2'h0;
            end else if (st_go) begin
                step_ff <= step_ff + 2'h1;
            end
        end
    end

    // ==========================================================
    // Buffer contents, no reset: software initialises them
    // CPU and store never write one buffer in the same cycle
    always @(posedge clk_sys) begin
        if (b_wr && bfld == `CRS_F_ID)
            bid_ff[bidx] <= reg_wdata[28:0];
        if (b_wr && bfld == `CRS_F_DLO)
            dlo_ff[bidx] <= reg_wdata;
        if (b_wr && bfld == `CRS_F_DHI)
            dhi_ff[bidx] <= reg_wdata;
        if (st_go) begin
            case (step_ff)
                2'h0:    bid_ff[tgt_ff] <= cap_id_ff;
                2'h1:    dlo_ff[tgt_ff] <= cap_data_ff[31:0];
                default: dhi_ff[tgt_ff] <= cap_data_ff[63:32];
            endcase
        end
    end

    // ==========================================================
    // Buffer control bits; hardware sets win over CPU writes
    integer i;
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rdy_ff    <= 16'h0000;
            stored_ff <= 16'h0000;
            muc_ff    <= 16'h0000;
            ows_ff    <= 16'h0000;
            inuse_ff  <= 16'h0000;
            for (i = 0; i < `CRS_NBUF; i = i + 1)
                type_ff[i] <= 3'h0;
            for (i = 0; i < 4; i = i + 1)
                mask_ff[i] <= `CRS_MASK_RST;
        end else begin
            if (reg_wr && msk_sel)
                mask_ff[reg_addr[1:0]] <= reg_wdata[28:0];
            if (b_wr && bfld == `CRS_F_CTRL) begin
                // Ready is frozen while its own buffer's update flag is set
                if (!muc_ff[bidx])
                    rdy_ff[bidx] <= reg_wdata[`CRS_C_RDY];  // RL4
                stored_ff[bidx] <= reg_wdata[`CRS_C_STORED];
                ows_ff[bidx]    <= reg_wdata[`CRS_C_OWS];
                inuse_ff[bidx]  <= reg_wdata[`CRS_C_INUSE];
                type_ff[bidx]   <= reg_wdata[`CRS_C_TYPE_LSB +: 3];
            end
            // First setting of the stored flag, update begins
            if (st_first) begin
                stored_ff[tgt_ff] <= 1'b1;                  // RL1
                muc_ff[tgt_ff]    <= 1'b1;                  // RL2
            end
            // Second setting, update ends in the same cycle
            if (st_end) begin
                stored_ff[tgt_ff] <= 1'b1;                  // RL1
                muc_ff[tgt_ff]    <= 1'b0;                  // RL2
            end
        end
    end

    // ==========================================================
    // Log entries, no reset: contents undefined after init
    wire [4:0] log_wa = log_overflow_ff ? ptr_dec(wptr_ff)
                                        : wptr_ff;          // RL13 RL9
    always @(posedge clk_sys) begin
        if (rec)
            log_ff[log_wa] <= {tgt_ff};                     // RL3 RL6
    end

    // ==========================================================
    // Log pointers and flags
    reg [4:0] nxt_wptr;
    reg [4:0] nxt_rptr;
    reg       nxt_empty;
    reg       nxt_ovf;
    always @* begin
        nxt_wptr  = wptr_ff;
        nxt_rptr  = rptr_ff;
        nxt_empty = log_empty_ff;
        nxt_ovf   = log_overflow_ff;
        if (ovf_clr)
            nxt_ovf = 1'b0;                                 // RL14
        if (get_rd && !log_empty_ff)
            nxt_rptr = ptr_inc(rptr_ff);                    // RL10
        if (rec && !log_overflow_ff) begin
            nxt_wptr  = ptr_inc(wptr_ff);                   // RL9
            nxt_empty = 1'b0;                               // RL11 RL15
            if (nxt_wptr == ptr_dec(nxt_rptr))
                nxt_ovf = 1'b1;                             // RL12
        end else if (get_rd && !log_empty_ff) begin
            nxt_empty = (nxt_rptr == wptr_ff);              // RL11
        end
    end

    // Init mode holds the log at its start point
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wptr_ff         <= `CRS_PTR_RST;
            rptr_ff         <= `CRS_PTR_RST;
            log_empty_ff    <= 1'b1;
            log_overflow_ff <= 1'b0;
        end else if (!mode_ff) begin
            wptr_ff         <= `CRS_PTR_RST;                // RL7
            rptr_ff         <= `CRS_PTR_RST;
            log_empty_ff    <= 1'b1;
            log_overflow_ff <= 1'b0;
        end else begin
            wptr_ff         <= nxt_wptr;
            rptr_ff         <= nxt_rptr;
            log_empty_ff    <= nxt_empty;
            log_overflow_ff <= nxt_ovf;
        end
    end

    // ==========================================================
    // Mode register
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            mode_ff <= 1'b0;
        else if (reg_wr && reg_addr == `CRS_A_MODE)
            mode_ff <= reg_wdata[`CRS_MODE_OP];
    end

    // ==========================================================
    // Read data mux
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        if (buf_sel) begin
            case (bfld)
                `CRS_F_CTRL: begin
                    rd_mux[`CRS_C_RDY]         = rdy_ff[bidx];
                    rd_mux[`CRS_C_STORED]      = stored_ff[bidx];
                    rd_mux[`CRS_C_MUC]         = muc_ff[bidx];
                    rd_mux[`CRS_C_OWS]         = ows_ff[bidx];
                    rd_mux[`CRS_C_INUSE]       = inuse_ff[bidx];
                    rd_mux[`CRS_C_TYPE_LSB+:3] = type_ff[bidx];
                end
                `CRS_F_ID:  rd_mux[28:0] = bid_ff[bidx];
                `CRS_F_DLO: rd_mux = dlo_ff[bidx];
                default:    rd_mux = dhi_ff[bidx];
            endcase
        end else if (msk_sel) begin
            rd_mux[28:0] = mask_ff[reg_addr[1:0]];
        end else begin
            case (reg_addr)
                `CRS_A_MODE: rd_mux[`CRS_MODE_OP] = mode_ff;
                `CRS_A_GET: begin
                    rd_mux[3:0]            = log_ff[rptr_ff]; // RL10
                    rd_mux[`CRS_GET_EMPTY] = log_empty_ff;
                    rd_mux[`CRS_GET_OVF]   = log_overflow_ff;
                end
                `CRS_A_LAST:
                    rd_mux[3:0] = log_ff[ptr_dec(wptr_ff)];   // RL8
                `CRS_A_PTR: begin
                    rd_mux[4:0]                 = rptr_ff;
                    rd_mux[`CRS_PTR_W_LSB +: 5] = wptr_ff;
                end
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Read data stands for one cycle after the strobe
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            reg_rdata_ff <= 32'h0000_0000;
        else if (reg_rd)
            reg_rdata_ff <= rd_mux;
        else
            reg_rdata_ff <= 32'h0000_0000;
    end

endmodule // crs_rx_store
`default_nettype wire

// File: logic/crs_rx_store_map.vh
// Address map, field positions and reset values of the receive store
// Assumes word-indexed register port, 8-bit address, 32-bit data
`ifndef CRS_RX_STORE_MAP_VH
`define CRS_RX_STORE_MAP_VH

// ==========================================================
// Register indices
`define CRS_A_MODE      8'h00
`define CRS_A_GET       8'h01
`define CRS_A_LAST      8'h02
`define CRS_A_PTR       8'h03
`define CRS_A_MASK_HI   6'h01
`define CRS_A_BUF_HI    2'h1
`define CRS_F_CTRL      2'h0
`define CRS_F_ID        2'h1
`define CRS_F_DLO       2'h2
`define CRS_F_DHI       2'h3

// ==========================================================
// Field positions
`define CRS_MODE_OP     0
`define CRS_GET_EMPTY   8
`define CRS_GET_OVF     9
`define CRS_PTR_W_LSB   8
`define CRS_C_RDY       0
`define CRS_C_STORED    1
`define CRS_C_MUC       2
`define CRS_C_OWS       3
`define CRS_C_INUSE     4
`define CRS_C_TYPE_LSB  5

// ==========================================================
// Sizes, codes, reset values
`define CRS_NBUF        16
`define CRS_LOG_LAST    5'h16
`define CRS_TYPE_NOMASK 3'h1
`define CRS_TYPE_MAX    3'h5
`define CRS_TYPE_NONE   3'h7
`define CRS_STEP_LAST   2'h2
`define CRS_PTR_RST     5'h00
`define CRS_MASK_RST    29'h0000_0000
`endif

// File: tb/crs_frame_src.sv
// Protocol engine model: hands over one frame per call
// Assumes the store's clock; no handshake back to the engine
`timescale 1ns/1ns
`default_nettype none
module crs_frame_src (
    input  wire logic        clk_sys,
    output var  logic        rx_frame_valid,
    output var  logic [28:0] rx_id,
    output var  logic [63:0] rx_data
);
    // ============================================================
    // Idle values at time zero
    initial begin
        rx_frame_valid = 1'b0;
        rx_id = 29'h0000_0000;
        rx_data = 64'h0000_0000_0000_0000;
    end
    // One-cycle frame pulse; id and data garbled afterwards so a
    // store that samples late reads wrong values
    task automatic send(input logic [28:0] id, input logic [63:0] d);
        @(posedge clk_sys);
        rx_frame_valid <= 1'b1;
        rx_id <= id;
        rx_data <= d;
        @(posedge clk_sys);
        rx_frame_valid <= 1'b0;
        rx_id <= ~id;
        rx_data <= ~d;
    endtask
endmodule // crs_frame_src
`default_nettype wire

// File: tb/crs_rx_store_checker.sv
// Port-level checker for the receive store
// Assumes one clock clk_sys and async active-low reset nrst
`timescale 1ns/1ns
`default_nettype none
module crs_rx_store_checker (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata_ff,
    input wire logic        rx_frame_valid,
    input wire logic        store_busy_ff,
    input wire logic        log_empty_ff,
    input wire logic        log_overflow_ff,
    input wire logic        rx_stored_pulse_ff
);
    // ============================================================
    // Clocking
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Writes that may drop overflow: get clear or a mode change
    wire ovf_clr = reg_wr && (reg_addr == 8'h01 || reg_addr == 8'h00);
    // ============================================================
    // Assertions
    chk_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata_ff == 0)
        else $error("read data seen outside its slot");
    chk_store_len: assert property ($rose(store_busy_ff) |->
        store_busy_ff[*5] ##[1:14] !store_busy_ff)
        else $error("store sequence length wrong");
    chk_store_cause: assert property ($rose(store_busy_ff) |->
        $past(rx_frame_valid)) else $error("store without a frame");
    chk_end_pulse: assert property ($fell(store_busy_ff) |->
        rx_stored_pulse_ff ##1 !rx_stored_pulse_ff)
        else $error("store end pulse missing");
    chk_empty_clr: assert property ($fell(log_empty_ff) |->
        store_busy_ff && !log_overflow_ff)
        else $error("empty cleared without record");
    chk_empty_keep: assert property (log_empty_ff && !store_busy_ff
        |=> log_empty_ff) else $error("empty dropped while idle");
    chk_empty_set: assert property ($rose(log_empty_ff) |->
        $past(reg_rd) || $past(reg_wr) || $past(reg_wr, 2))
        else $error("empty set without software access");
    chk_ovf_set: assert property ($rose(log_overflow_ff) |->
        store_busy_ff) else $error("overflow set outside a store");
    chk_ovf_stick: assert property (log_overflow_ff && !ovf_clr &&
        !$past(ovf_clr) |=> log_overflow_ff)
        else $error("overflow lost without clear");
    // Main scenarios reached
    cov_ovf: cover property ($rose(log_overflow_ff));
    cov_rec: cover property ($fell(log_empty_ff));
    cov_end: cover property (rx_stored_pulse_ff);
endmodule // crs_rx_store_checker
bind crs_rx_store crs_rx_store_checker u_chk (.clk_sys(clk_sys),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .rx_frame_valid(rx_frame_valid), .store_busy_ff(store_busy_ff),
    .log_empty_ff(log_empty_ff), .log_overflow_ff(log_overflow_ff),
    .rx_stored_pulse_ff(rx_stored_pulse_ff));
`default_nettype wire

// File: tb/crs_rx_store_tb.sv
// Testbench for the receive store: register tasks and frame calls
// Assumes the frame model and checker files compiled beforehand
`timescale 1ns/1ns
`default_nettype none
module crs_rx_store_tb;
    logic        clk_sys, nrst, reg_wr, reg_rd, rx_frame_valid;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata_ff;
    logic [28:0] rx_id;
    logic [63:0] rx_data;
    logic        store_busy_ff, log_empty_ff, log_overflow_ff;
    logic        rx_stored_pulse_ff;
    int          fails, comparisons, i;
    localparam logic [63:0] DAT = 64'h1111_2222_3333_4444;
    localparam logic [28:0] IDA = 29'h0000_0123;  // Unmasked buffer 0
    localparam logic [28:0] IDB = 29'h0012_3400;  // Buffers 1 and 2
    // ============================================================
    // Design and far side
    crs_rx_store u_crs_rx_store (.clk_sys(clk_sys), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .rx_frame_valid(rx_frame_valid), .rx_id(rx_id),
        .rx_data(rx_data), .store_busy_ff(store_busy_ff),
        .log_empty_ff(log_empty_ff), .log_overflow_ff(log_overflow_ff),
        .rx_stored_pulse_ff(rx_stored_pulse_ff));
    crs_frame_src u_src (.clk_sys(clk_sys),
        .rx_frame_valid(rx_frame_valid), .rx_id(rx_id),
        .rx_data(rx_data));
    // ============================================================
    // Clock, 100 ns period
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Watchdog well beyond the expected run of under a thousand cycles
    initial begin
        #(10000 * 100);
        fails++;
        results();
    end
    // ============================================================
    // Tasks
    task automatic results();
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read and compare the masked word in its one-cycle slot
    task automatic rc(input string n, input logic [7:0] a,
                      input logic [31:0] e, input logic [31:0] m);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(n, e, reg_rdata_ff & m);
    endtask
    // Send a frame; poke writes buffer 0 control mid-store
    task automatic frame(input logic [28:0] id, input logic exp,
                         input logic poke);
        logic got;
        got = 1'b0;
        // Inverted data on a poked store, so a stalled word that
        // lands late or not at all differs from the earlier frame
        u_src.send(id, DAT ^ {64{poke}});
        if (poke) begin
            @(posedge clk_sys);
            wr(8'h40, 32'h0000_0038);
        end
        repeat (20) begin
            @(posedge clk_sys);
            #1 if (rx_stored_pulse_ff === 1'b1) got = 1'b1;
        end
        chk("stored", {31'b0, exp}, {31'b0, got});
    endtask
    // ============================================================
    // Main sequence
    initial begin
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        fails = 0;
        comparisons = 0;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        #1 chk("empty", 1, log_empty_ff);
        chk("ovf", 0, log_overflow_ff);
        rc("mode", 8'h00, 0, 32'hFFFF_FFFF);
        rc("unmapped", 8'h30, 0, 32'hFFFF_FFFF);
        wr(8'h04, 32'h0000_00FF);
        wr(8'h41, IDA);
        wr(8'h45, IDB);
        wr(8'h49, IDB);
        wr(8'h40, 32'h0000_0039);
        wr(8'h44, 32'h0000_0051);
        wr(8'h48, 32'h0000_0071);
        wr(8'h00, 32'h0000_0001);
        frame(IDA, 1, 0);
        rc("last", 8'h02, 0, 32'h0000_000F);
        frame(IDA, 1, 1);
        rc("ctrl0", 8'h40, 32'h0000_003B, 32'hFFFF_FFFF);
        rc("dlo", 8'h42, ~DAT[31:0], 32'hFFFF_FFFF);
        rc("dhi", 8'h43, ~DAT[63:32], 32'hFFFF_FFFF);
        frame(29'h0012_34AB, 1, 0);
        rc("last", 8'h02, 1, 32'h0000_000F);
        frame(29'h0012_35AB, 0, 0);
        frame(IDB, 0, 0);
        wr(8'h44, 32'h0000_005B);
        frame(IDB, 1, 0);
        for (i = 0; i < 4; i++)
            rc("get", 8'h01, (i < 2) ? 0 : 1, 32'h0000_000F);
        chk("empty", 1, log_empty_ff);
        rc("get", 8'h01, 32'h0000_0100, 32'h0000_0100);
        rc("ptr", 8'h03, 32'h0000_0404, 32'hFFFF_FFFF);
        for (i = 0; i < 22; i++) frame(IDA, 1, 0);
        chk("ovf", 1, log_overflow_ff);
        chk("empty", 0, log_empty_ff);
        rc("ptr", 8'h03, 32'h0000_0304, 32'hFFFF_FFFF);
        frame(29'h0012_34AB, 1, 0);
        rc("last", 8'h02, 1, 32'h0000_000F);
        rc("ptr", 8'h03, 32'h0000_0304, 32'hFFFF_FFFF);
        for (i = 0; i < 22; i++)
            rc("get", 8'h01, (i < 21) ? 0 : 1, 32'h0000_000F);
        chk("empty", 1, log_empty_ff);
        chk("ovf", 1, log_overflow_ff);
        frame(IDA, 1, 0);
        chk("empty", 1, log_empty_ff);
        rc("last", 8'h02, 0, 32'h0000_000F);
        wr(8'h01, 32'h0000_0200);
        rc("getovf", 8'h01, 0, 32'h0000_0200);
        chk("ovf", 0, log_overflow_ff);
        wr(8'h00, 32'h0000_0000);
        repeat (2) @(posedge clk_sys);
        rc("ptr", 8'h03, 0, 32'hFFFF_FFFF);
        chk("empty", 1, log_empty_ff);
        results();
    end
endmodule // crs_rx_store_tb
`default_nettype wire
